// File: rtl/cpt_map.svh
// Register offsets, field positions and reset values of the port/timer block
// Notes on behaviour
// - Port one: eight lines, each with its own direction bit; read/write.
// - Port one input lines, except 3 and 4 in two-wire serial, and all lines after reset are undriven.
// - Port one lines 3 and 4 go to two-wire serial when selected.
// - Port one never outputs low address bits; plain port except lines 3 and 4 in two-wire serial.
// - Port two: five lines with direction; only lines 3 and 4 reach pins.
// - Port two lines 0 and 2 carry frequency counter and baud clock inputs.
// - Serial control enables override port two direction; transmit enable also overrides line 4 value.
// - Timer: 16-bit free counter, 8-bit control/status, 16-bit capture.
// - Timer drives no output waveform onto any pin.
// - Capture input comes from the frequency counter input, port two line 0.
// - Capture flag sets on selected edge; read of capture clears it.
// - Compare flag sets when counter equals compare register.
// - Overflow flag sets on counter overflow; counter read clears it.
// - Control bits 4, 3, 2 enable capture, compare, overflow interrupts.
// - Control bit 1: zero falling edge capture, one rising edge.
// - Counter advances once per processor clock, no further division.
// - Emulation bypasses internal core; core outputs never drive buses.
// - Selected capture edge loads counter value into capture register.
// - Counter reads clear the overflow flag; a word store loads both bytes at once.
`ifndef CPT_MAP_SVH
`define CPT_MAP_SVH
`define CPT_ADDR_P1_DIR 5'h00
`define CPT_ADDR_P2_DIR 5'h01
`define CPT_ADDR_P1_VAL 5'h02
`define CPT_ADDR_P2_VAL 5'h03
`define CPT_ADDR_TCS 5'h08
`define CPT_ADDR_CNT 5'h09
`define CPT_ADDR_CMP 5'h0B
`define CPT_ADDR_CAP 5'h0D
`define CPT_ADDR_SER 5'h11
`define CPT_ADDR_SEL 5'h12
`define CPT_CNT_RST 16'h0000
`define CPT_CMP_RST 16'hFFFF
`define CPT_CNT_MAX 16'hFFFF
`define CPT_BIT_CAPF 7
`define CPT_BIT_CMPF 6
`define CPT_BIT_OVF 5
`define CPT_BIT_CAPE 4
`define CPT_BIT_CMPE 3
`define CPT_BIT_OVE 2
`define CPT_BIT_EDGE 1
`define CPT_BIT_RXEN 3
`define CPT_BIT_TXEN 1
`define CPT_BIT_I2C 2
`define CPT_LINE_RX 3
`define CPT_LINE_TX 4
`define CPT_LINE_FC 0
`define CPT_LINE_BAUD 2
`endif

// File: rtl/cpt_pkg.sv
// Types shared by the port/timer block
package cpt_pkg;
  typedef enum logic [1:0] {
    CPT_IDLE,
    CPT_DONE
  } cpt_bus_state_type;
  typedef logic [15:0] cpt_word_type;
endpackage

// File: rtl/cpt_reg_if.sv
// Register access strobes between bus slave and timer
`timescale 1ns/1ps
interface cpt_reg_if;
  logic wr;
  logic rd;
  logic [4:0] addr;
  logic [15:0] wdata;
  logic [1:0] be;
  modport slave (output wr, output rd, output addr, output wdata, output be);
  modport user (input wr, input rd, input addr, input wdata, input be);
endinterface

// File: rtl/cpt_port_line.sv
// One general-purpose port line with direction and value
`timescale 1ns/1ps
module cpt_port_line (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic dir_we_i,
  input wire logic dir_d_i,
  input wire logic val_we_i,
  input wire logic val_d_i,
  input wire logic pin_i,
  output logic dir_o,
  output logic rd_o,
  output logic pin_o,
  output logic pin_oe_o
);
  logic dir_ff;
  logic val_ff;
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      dir_ff <= 1'b0;
    end else if (dir_we_i) begin
      dir_ff <= dir_d_i;
    end
  end
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      val_ff <= 1'b0;
    end else if (val_we_i) begin
      val_ff <= val_d_i;
    end
  end
  assign dir_o = dir_ff;
  assign pin_oe_o = dir_ff;
  assign pin_o = val_ff;
  // Outputs read back latch, inputs read the pin
  assign rd_o = dir_ff ? val_ff : pin_i;
endmodule // cpt_port_line

// File: rtl/cpt_timer.sv
// Free-running counter with capture, compare and overflow flags
`timescale 1ns/1ps
`include "cpt_map.svh"
module cpt_timer (
  input wire logic clk_i,
  input wire logic reset_n_i,
  cpt_reg_if.user reg_if,
  input wire logic capture_input_i,
  output logic [7:0] tcs_o,
  output logic [15:0] cnt_o,
  output logic [15:0] cmp_o,
  output logic [15:0] cap_o,
  output logic irq_o
);
  logic [15:0] cnt_ff;
  logic [15:0] cmp_ff;
  logic [15:0] cap_ff;
  logic [4:0] ctl_ff;
  logic capf_ff;
  logic cmpf_ff;
  logic ovf_ff;
  logic in_ff;
  logic edge_hit;
  logic cnt_wr;
  logic cnt_rd;
  logic cap_rd;
  assign cnt_wr = reg_if.wr && reg_if.addr == 5'(`CPT_ADDR_CNT);
  assign cnt_rd = reg_if.rd && reg_if.addr == 5'(`CPT_ADDR_CNT);
  assign cap_rd = reg_if.rd && reg_if.addr == 5'(`CPT_ADDR_CAP);
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      in_ff <= 1'b0;
    end else begin
      in_ff <= capture_input_i;
    end
  end
  assign edge_hit = ctl_ff[`CPT_BIT_EDGE] ?
    (capture_input_i && !in_ff) : (!capture_input_i && in_ff);
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cnt_ff <= `CPT_CNT_RST;
    end else if (cnt_wr) begin
      if (reg_if.be[0]) cnt_ff[7:0] <= reg_if.wdata[7:0];
      if (reg_if.be[1]) cnt_ff[15:8] <= reg_if.wdata[15:8];
    end else begin
      cnt_ff <= cnt_ff + 16'h0001;
    end
  end
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cmp_ff <= `CPT_CMP_RST;
    end else if (reg_if.wr && reg_if.addr == 5'(`CPT_ADDR_CMP)) begin
      if (reg_if.be[0]) cmp_ff[7:0] <= reg_if.wdata[7:0];
      if (reg_if.be[1]) cmp_ff[15:8] <= reg_if.wdata[15:8];
    end
  end
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cap_ff <= `CPT_CNT_RST;
    end else if (edge_hit) begin
      cap_ff <= cnt_ff;
    end
  end
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ctl_ff <= 5'h00;
    end else if (reg_if.wr && reg_if.addr == 5'(`CPT_ADDR_TCS)
                 && reg_if.be[0]) begin
      ctl_ff <= reg_if.wdata[4:0];
    end
  end
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      capf_ff <= 1'b0;
    end else if (edge_hit) begin
      capf_ff <= 1'b1;
    end else if (cap_rd) begin
      capf_ff <= 1'b0;
    end
  end
  // compare match flag; cleared by compare write
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cmpf_ff <= 1'b0;
    end else if (cnt_ff == cmp_ff) begin
      cmpf_ff <= 1'b1;
    end else if (reg_if.wr && reg_if.addr == 5'(`CPT_ADDR_CMP)) begin
      cmpf_ff <= 1'b0;
    end
  end
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ovf_ff <= 1'b0;
    end else if (!cnt_wr && cnt_ff == `CPT_CNT_MAX) begin
      ovf_ff <= 1'b1;
    end else if (cnt_rd) begin
      ovf_ff <= 1'b0;
    end
  end
  assign tcs_o = {capf_ff, cmpf_ff, ovf_ff, ctl_ff};
  assign cnt_o = cnt_ff;
  assign cmp_o = cmp_ff;
  assign cap_o = cap_ff;
  assign irq_o = (capf_ff && ctl_ff[`CPT_BIT_CAPE]) ||
                 (cmpf_ff && ctl_ff[`CPT_BIT_CMPE]) ||
                 (ovf_ff && ctl_ff[`CPT_BIT_OVE]);
endmodule // cpt_timer

// File: rtl/cpt_top.sv
// Port/timer peripheral kernel with Avalon-MM register slave
//
// The register offsets and the Avalon-MM register port were left to the implementer.
`timescale 1ns/1ps
`include "cpt_map.svh"
module cpt_top (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic [4:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  input wire logic emulation_select_pin_i,
  input wire logic [7:0] port_one_pin_i,
  output logic [7:0] port_one_pin_o,
  output logic [7:0] port_one_pin_oe_o,
  input wire logic [4:3] port_two_pin_i,
  output logic [4:3] port_two_pin_o,
  output logic [4:3] port_two_pin_oe_o,
  input wire logic frequency_counter_i,
  input wire logic baud_clock_i,
  input wire logic serial_tx_i,
  output logic serial_rx_o,
  input wire logic i2c_scl_i,
  input wire logic i2c_scl_oe_i,
  input wire logic i2c_sda_i,
  input wire logic i2c_sda_oe_i,
  output logic i2c_scl_o,
  output logic i2c_sda_o,
  output logic interrupt_request_line_o,
  output logic core_bus_enable_o
);
  cpt_reg_if reg_if ();
  cpt_pkg::cpt_bus_state_type state_ff;
  logic [31:0] rdata_ff;
  logic [31:0] nxt_rdata;
  logic [7:0] ser_ff;
  logic [7:0] sel_ff;
  logic [7:0] p1_dir, p1_rd, p1_o, p1_oe;
  logic [4:0] p2_dir, p2_rd, p2_o, p2_oe, p2_in;
  logic [7:0] tcs;
  logic [15:0] cnt, cmp, cap;
  logic irq;
  logic req;
  logic hit_p1d, hit_p1v, hit_p2d, hit_p2v;
  assign req = (avs_read_i || avs_write_i) && state_ff == cpt_pkg::CPT_IDLE;
  assign reg_if.wr = req && avs_write_i;
  assign reg_if.rd = req && avs_read_i;
  assign reg_if.addr = avs_address_i;
  assign reg_if.wdata = avs_writedata_i[15:0];
  assign reg_if.be = avs_byteenable_i[1:0];
  assign hit_p1d = reg_if.wr && avs_address_i == 5'(`CPT_ADDR_P1_DIR);
  assign hit_p1v = reg_if.wr && avs_address_i == 5'(`CPT_ADDR_P1_VAL);
  assign hit_p2d = reg_if.wr && avs_address_i == 5'(`CPT_ADDR_P2_DIR);
  assign hit_p2v = reg_if.wr && avs_address_i == 5'(`CPT_ADDR_P2_VAL);
  // One wait cycle per access; answer on second cycle
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_ff <= cpt_pkg::CPT_IDLE;
    end else begin
      unique case (state_ff)
        cpt_pkg::CPT_IDLE: begin
          if (avs_read_i || avs_write_i) state_ff <= cpt_pkg::CPT_DONE;
        end
        cpt_pkg::CPT_DONE: state_ff <= cpt_pkg::CPT_IDLE;
      endcase
    end
  end
  assign avs_waitrequest_o = state_ff != cpt_pkg::CPT_DONE;
  always_comb begin
    nxt_rdata = 32'h0000_0000;
    unique case (avs_address_i)
      5'(`CPT_ADDR_P1_DIR): nxt_rdata[7:0] = p1_dir;
      5'(`CPT_ADDR_P2_DIR): nxt_rdata[4:0] = p2_dir;
      5'(`CPT_ADDR_P1_VAL): nxt_rdata[7:0] = p1_rd;
      5'(`CPT_ADDR_P2_VAL): nxt_rdata[4:0] = p2_rd;
      5'(`CPT_ADDR_TCS): nxt_rdata[7:0] = tcs;
      5'(`CPT_ADDR_CNT): nxt_rdata[15:0] = cnt;
      5'(`CPT_ADDR_CMP): nxt_rdata[15:0] = cmp;
      5'(`CPT_ADDR_CAP): nxt_rdata[15:0] = cap;
      5'(`CPT_ADDR_SER): nxt_rdata[7:0] = ser_ff;
      5'(`CPT_ADDR_SEL): nxt_rdata[7:0] = sel_ff;
      default: nxt_rdata = 32'h0000_0000;
    endcase
  end
  // Read data sampled at the taking edge, so clear-on-read is consistent
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rdata_ff <= 32'h0000_0000;
    end else if (reg_if.rd) begin
      rdata_ff <= nxt_rdata;
    end
  end
  assign avs_readdata_o = rdata_ff;
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ser_ff <= 8'h00;
    end else if (reg_if.wr && avs_address_i == 5'(`CPT_ADDR_SER)
                 && avs_byteenable_i[0]) begin
      ser_ff <= avs_writedata_i[7:0];
    end
  end
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      sel_ff <= 8'h00;
    end else if (reg_if.wr && avs_address_i == 5'(`CPT_ADDR_SEL)
                 && avs_byteenable_i[0]) begin
      sel_ff <= avs_writedata_i[7:0];
    end
  end
  // port one lines, plain I/O only
  for (genvar i = 0; i < 8; i++) begin : g_p1
    cpt_port_line u_line (
      .clk_i(clk_i),
      .reset_n_i(reset_n_i),
      .dir_we_i(hit_p1d && avs_byteenable_i[0]),
      .dir_d_i(avs_writedata_i[i]),
      .val_we_i(hit_p1v && avs_byteenable_i[0]),
      .val_d_i(avs_writedata_i[i]),
      .pin_i(port_one_pin_i[i]),
      .dir_o(p1_dir[i]),
      .rd_o(p1_rd[i]),
      .pin_o(p1_o[i]),
      .pin_oe_o(p1_oe[i])
    );
  end
  assign p2_in = {port_two_pin_i, baud_clock_i, 1'b0, frequency_counter_i};
  for (genvar i = 0; i < 5; i++) begin : g_p2
    cpt_port_line u_line (
      .clk_i(clk_i),
      .reset_n_i(reset_n_i),
      .dir_we_i(hit_p2d && avs_byteenable_i[0]),
      .dir_d_i(avs_writedata_i[i]),
      .val_we_i(hit_p2v && avs_byteenable_i[0]),
      .val_d_i(avs_writedata_i[i]),
      .pin_i(p2_in[i]),
      .dir_o(p2_dir[i]),
      .rd_o(p2_rd[i]),
      .pin_o(p2_o[i]),
      .pin_oe_o(p2_oe[i])
    );
  end
  // two-wire serial shares lines 3 and 4
  always_comb begin
    port_one_pin_o = p1_o;
    port_one_pin_oe_o = p1_oe;
    if (sel_ff[`CPT_BIT_I2C]) begin
      port_one_pin_o[3] = 1'b0;
      port_one_pin_oe_o[3] = i2c_scl_oe_i;
      port_one_pin_o[4] = 1'b0;
      port_one_pin_oe_o[4] = i2c_sda_oe_i;
    end
  end
  assign i2c_scl_o = port_one_pin_i[3] && i2c_scl_i;
  assign i2c_sda_o = port_one_pin_i[4] && i2c_sda_i;
  always_comb begin
    port_two_pin_o = p2_o[4:3];
    port_two_pin_oe_o = p2_oe[4:3];
    if (ser_ff[`CPT_BIT_RXEN]) port_two_pin_oe_o[`CPT_LINE_RX] = 1'b0;
    if (ser_ff[`CPT_BIT_TXEN]) begin
      port_two_pin_oe_o[`CPT_LINE_TX] = 1'b1;
      port_two_pin_o[`CPT_LINE_TX] = serial_tx_i;
    end
  end
  assign serial_rx_o = port_two_pin_i[`CPT_LINE_RX];
  // timer, no pin output, fed by frequency counter
  cpt_timer u_timer (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .reg_if(reg_if),
    .capture_input_i(frequency_counter_i),
    .tcs_o(tcs),
    .cnt_o(cnt),
    .cmp_o(cmp),
    .cap_o(cap),
    .irq_o(irq)
  );
  assign interrupt_request_line_o = irq;
  // emulation removes the internal core from the buses
  assign core_bus_enable_o = !emulation_select_pin_i;
endmodule // cpt_top

// File: tb/cpt_monitor.sv
// Checker for bus handshake and pin behaviour of the port/timer block
`timescale 1ns/1ps
module cpt_monitor (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic [4:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic avs_waitrequest_o,
  input wire logic emulation_select_pin_i,
  input wire logic [7:0] port_one_pin_o,
  input wire logic [7:0] port_one_pin_oe_o,
  input wire logic [4:3] port_two_pin_i,
  input wire logic serial_rx_o,
  input wire logic core_bus_enable_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  // Lines 3 and 4 may be lent to the two-wire serial
  localparam logic [7:0] plain_m = 8'he7;
  sequence taken_s;
    (avs_read_i || avs_write_i) && avs_waitrequest_o;
  endsequence
  sequence dir1_s;
    taken_s ##0 avs_write_i && avs_address_i == 5'h00;
  endsequence
  sequence val1_s;
    taken_s ##0 avs_write_i && avs_address_i == 5'h02;
  endsequence
  ack_next_a:
    assert property (taken_s |=> !avs_waitrequest_o ##1 avs_waitrequest_o)
    else $error("answer not one cycle after request");
  wait_idle_a:
    assert property (!(avs_read_i || avs_write_i) |-> avs_waitrequest_o)
    else $error("waitrequest low while idle");
  rdata_hold_a:
    assert property ($changed(avs_readdata_o) |->
      $past(avs_read_i && avs_waitrequest_o))
    else $error("read data moved without a read");
  core_off_a:
    assert property (core_bus_enable_o == !emulation_select_pin_i)
    else $error("core bus enable wrong for mode");
  rst_hiz_a:
    assert property ($rose(reset_n_i) |-> port_one_pin_oe_o == 8'h00)
    else $error("port one driven after reset");
  dir_out_a:
    assert property (dir1_s |=> (port_one_pin_oe_o & plain_m) ==
      ($past(avs_writedata_i[7:0]) & plain_m))
    else $error("port one enables differ from direction");
  val_out_a:
    assert property (val1_s |=> ((port_one_pin_o ^
      $past(avs_writedata_i[7:0])) & port_one_pin_oe_o & plain_m) == 8'h00)
    else $error("port one output differs from value");
  rx_pass_a:
    assert property (serial_rx_o == port_two_pin_i[3])
    else $error("serial receive not from line 3");
endmodule // cpt_monitor
bind cpt_top cpt_monitor mon (.clk_i, .reset_n_i, .avs_address_i,
  .avs_read_i, .avs_write_i, .avs_writedata_i, .avs_readdata_o,
  .avs_waitrequest_o, .emulation_select_pin_i, .port_one_pin_o,
  .port_one_pin_oe_o, .port_two_pin_i, .serial_rx_o, .core_bus_enable_o);

// File: tb/cpt_pins.sv
// Far-side pin drivers of both ports
`timescale 1ns/1ps
module cpt_pins (
  input wire logic [7:0] p1_o_i,
  input wire logic [7:0] p1_oe_i,
  input wire logic [7:0] p1_ext_i,
  input wire logic [4:3] p2_o_i,
  input wire logic [4:3] p2_oe_i,
  input wire logic [4:3] p2_ext_i,
  output logic [7:0] p1_pin_o,
  output logic [4:3] p2_pin_o
);
  assign p1_pin_o = (p1_o_i & p1_oe_i) | (p1_ext_i & ~p1_oe_i);
  assign p2_pin_o = (p2_o_i & p2_oe_i) | (p2_ext_i & ~p2_oe_i);
endmodule // cpt_pins

// File: tb/cpt_top_test.sv
// Self-checking bench for the port/timer block
`timescale 1ns/1ps
module cpu_ports_capture_timer_test;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic [4:0] adr = 5'h00;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wd = 32'h0000_0000;
  logic [3:0] be = 4'h3;
  logic fc = 1'b0;
  logic tx = 1'b0;
  logic emu = 1'b0;
  logic i2c_oe = 1'b0;
  logic [7:0] ext1 = 8'h00;
  logic [4:3] ext2 = 2'b00;
  logic [7:0] p1_i, p1_o, p1_oe;
  logic [4:3] p2_i, p2_o, p2_oe;
  logic [31:0] rdata;
  logic irq, wtr, core_en;
  int cyc = 0;
  int num_errors = 0;
  int comparisons = 0;
  int tk;
  always #4 clk = ~clk;
  always @(posedge clk) cyc <= cyc + 1;
  cpt_top dut (.clk_i(clk), .reset_n_i(reset_n), .avs_address_i(adr),
    .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wd),
    .avs_byteenable_i(be), .avs_readdata_o(rdata),
    .avs_waitrequest_o(wtr), .emulation_select_pin_i(emu),
    .port_one_pin_i(p1_i), .port_one_pin_o(p1_o), .port_one_pin_oe_o(p1_oe),
    .port_two_pin_i(p2_i), .port_two_pin_o(p2_o), .port_two_pin_oe_o(p2_oe),
    .frequency_counter_i(fc), .baud_clock_i(1'b0), .serial_tx_i(tx),
    .serial_rx_o(), .i2c_scl_i(tx), .i2c_scl_oe_i(i2c_oe), .i2c_sda_i(fc),
    .i2c_sda_oe_i(i2c_oe), .i2c_scl_o(), .i2c_sda_o(),
    .interrupt_request_line_o(irq), .core_bus_enable_o(core_en));
  cpt_pins far (.p1_o_i(p1_o), .p1_oe_i(p1_oe), .p1_ext_i(ext1),
    .p2_o_i(p2_o), .p2_oe_i(p2_oe), .p2_ext_i(ext2),
    .p1_pin_o(p1_i), .p2_pin_o(p2_i));
  task automatic chk_reg(input string n, input logic [31:0] e,
    input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic chk_pin(input string n, input logic [7:0] e,
    input logic [7:0] g);
    comparisons++;
    if (g !== e) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  // Request held until waitrequest is seen low at an edge
  task automatic bus(input logic w, input logic [4:0] a,
    input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    adr <= a;
    wr <= w;
    rd <= !w;
    wd <= d;
    do begin
      @(posedge clk);
      if (n == 0) tk = cyc;
      n++;
    end while (wtr !== 1'b0);
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
    // Idle edge so the next request never reassigns in this step
    @(posedge clk);
  endtask
  task automatic test_done();
    $display("comparisons %0d errors %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // Whole run is a couple of hundred cycles
  initial begin
    #400_000;
    num_errors++;
    test_done();
  end
  initial begin
    logic [31:0] q, v;
    logic [7:0] d1;
    logic [4:0] d2;
    logic [15:0] x;
    logic eb;
    int t0, t1;
    logic [4:0] ra [5];
    logic [15:0] rv [5];
    ra = '{5'h00, 5'h01, 5'h08, 5'h0B, 5'h0D};
    rv = '{16'h0000, 16'h0000, 16'h0000, 16'hFFFF, 16'h0000};
    v = $urandom(96);
    repeat (5) @(posedge clk);
    reset_n <= 1'b1;
    chk_pin("oe after reset", 8'h00, p1_oe);
    chk_pin("core enable", 8'h01, {7'h00, core_en});
    for (int i = 0; i < 5; i++) begin
      bus(1'b0, ra[i], 32'h0000_0000, q);
      chk_reg("reset value", {16'h0000, rv[i]}, q);
    end
    bus(1'b1, 5'h1F, 32'hFFFF_FFFF, q);
    bus(1'b0, 5'h1F, 32'h0000_0000, q);
    chk_reg("unmapped", 32'h0000_0000, q);
    repeat (3) begin
      d1 = 8'($urandom);
      v = $urandom;
      ext1 <= 8'($urandom);
      bus(1'b1, 5'h00, {24'h00_0000, d1}, q);
      bus(1'b1, 5'h02, v, q);
      bus(1'b0, 5'h02, 32'h0000_0000, q);
      chk_reg("p1 value", {24'h00_0000, (v[7:0] & d1) | (ext1 & ~d1)}, q);
      chk_pin("p1 oe", d1, p1_oe);
      chk_pin("p1 out", v[7:0] & d1, p1_o & p1_oe);
    end
    // lines 3 and 4 lent to the two-wire serial
    bus(1'b1, 5'h00, 32'h0000_00FF, q);
    bus(1'b1, 5'h12, 32'h0000_0004, q);
    chk_pin("i2c released", 8'hE7, p1_oe);
    i2c_oe <= 1'b1;
    @(posedge clk);
    chk_pin("i2c driven", 8'hFF, p1_oe);
    chk_pin("i2c low", 8'h00, p1_o & 8'h18);
    i2c_oe <= 1'b0;
    bus(1'b1, 5'h12, 32'h0000_0000, q);
    // lines 0 and 2 kept inputs
    d2 = 5'($urandom) & 5'h1A;
    ext2 <= 2'($urandom);
    fc <= 1'b1;
    tx <= 1'b1;
    bus(1'b1, 5'h01, {27'h000_0000, d2}, q);
    bus(1'b1, 5'h03, v, q);
    bus(1'b0, 5'h03, 32'h0000_0000, q);
    chk_reg("p2 value", {27'h000_0000,
      (v[4:3] & d2[4:3]) | (ext2 & ~d2[4:3]), 1'b0, d2[1] & v[1],
      1'b1}, q);
    chk_pin("p2 oe", {6'h00, d2[4:3]}, {6'h00, p2_oe});
    bus(1'b1, 5'h11, 32'h0000_000A, q);
    chk_pin("serial oe", 8'h02, {6'h00, p2_oe});
    chk_pin("serial tx", 8'h01, {7'h00, p2_o[4]});
    bus(1'b1, 5'h11, 32'h0000_0000, q);
    bus(1'b1, 5'h0B, 32'h0000_FFF8, q);
    bus(1'b1, 5'h09, 32'h0000_FFF0, q);
    t0 = tk;
    repeat (24) @(posedge clk);
    bus(1'b0, 5'h08, 32'h0000_0000, q);
    chk_reg("flags at wrap", 32'h0000_0060, q);
    repeat (2) begin
      bus(1'b0, 5'h09, 32'h0000_0000, q);
      x = 16'hFFF0 + 16'(tk - t0 - 1);
      chk_reg("count", {16'h0000, x}, q);
    end
    bus(1'b0, 5'h08, 32'h0000_0000, q);
    chk_reg("overflow cleared", 32'h0000_0040, q);
    bus(1'b1, 5'h0B, 32'h0000_1234, q);
    bus(1'b0, 5'h08, 32'h0000_0000, q);
    chk_reg("compare cleared", 32'h0000_0000, q);
    for (int e = 0; e < 2; e++) begin
      eb = e[0];
      fc <= eb;
      bus(1'b1, 5'h08, {27'h000_0000, 1'b1, 2'b00, eb, 1'b0}, q);
      bus(1'b0, 5'h0D, 32'h0000_0000, q);
      bus(1'b1, 5'h09, 32'h0000_0000, q);
      t0 = tk;
      fc <= !eb;
      repeat (4) @(posedge clk);
      chk_pin("irq wrong edge", 8'h00, {7'h00, irq});
      fc <= eb;
      t1 = cyc;
      repeat (4) @(posedge clk);
      chk_pin("irq capture", 8'h01, {7'h00, irq});
      bus(1'b0, 5'h08, 32'h0000_0000, q);
      chk_reg("capture flag", {24'h00_0000, 8'h90 | {6'h00, eb, 1'b0}}, q);
      bus(1'b0, 5'h0D, 32'h0000_0000, q);
      chk_reg("capture", 32'(t1 - t0), q);
      bus(1'b0, 5'h08, 32'h0000_0000, q);
      chk_reg("flag cleared", {24'h00_0000, 8'h10 | {6'h00, eb, 1'b0}}, q);
    end
    // bench stands in for the outside processor
    emu <= 1'b1;
    bus(1'b1, 5'h00, 32'h0000_005A, q);
    chk_pin("core off", 8'h00, {7'h00, core_en});
    bus(1'b0, 5'h00, 32'h0000_0000, q);
    chk_reg("emulated access", 32'h0000_005A, q);
    emu <= 1'b0;
    test_done();
  end
endmodule // cpu_ports_capture_timer_test
